/* File: pkg/pms_defs.svh */
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

// ****************************************
// instruction codes and frame layout
// ****************************************
`define PMS_OP_SWITCH 8'h0b
`define PMS_OP_AUTH 8'h0c
`define PMS_LEN_STANDBY 4'h4
`define PMS_LEN_LOW_POWER_CARD_DETECT 4'h3
`define PMS_LEN_LISTEN 4'h3
`define PMS_LEN_AUTH 4'hc
`define PMS_IDX_MAX 4'hf
`define PMS_IDX_MODE 4'h0
`define PMS_IDX_P1 4'h1
`define PMS_IDX_P2 4'h2
`define PMS_IDX_P3 4'h3
`define PMS_AUTH_TYPE_IDX 4'h6
`define PMS_AUTH_BLOCK_IDX 4'h7
`define PMS_AUTH_UID_IDX 8

// ****************************************
// mode byte, sub-modes, masks
// ****************************************
`define PMS_MODE_STANDBY 8'h00
`define PMS_MODE_LOW_POWER_CARD_DETECT 8'h01
`define PMS_MODE_LISTEN 8'h02
`define PMS_SUB_EXIT 8'h00
`define PMS_SUB_SLEEP 8'h01
`define PMS_SUB_AWAKE 8'h02
`define PMS_WAKE_CNT_BIT 0
`define PMS_WAKE_RF_BIT 1
`define PMS_WAKE_RSV_MSB 7
`define PMS_WAKE_RSV_LSB 2
`define PMS_TECH_RSV_MSB 7
`define PMS_TECH_RSV_LSB 4
`define PMS_CNT_MIN 16'h0001
`define PMS_CNT_MAX 16'h0a82
`define PMS_KEY_A 8'h60
`define PMS_KEY_B 8'h61

// ****************************************
// authentication status byte
// ****************************************
`define PMS_AUTH_OK 8'h00
`define PMS_AUTH_DENIED 8'h01
`define PMS_AUTH_TIMEOUT 8'h02

// ****************************************
// timing
// ****************************************
`define PMS_MS_NS 1000000
`define PMS_CLK_NS 40

// ****************************************
// register map and fields
// ****************************************
`define PMS_REG_CTRL 8'h00
`define PMS_REG_STATUS 8'h04
`define PMS_REG_WAKE 8'h08
`define PMS_REG_LISTEN 8'h0c
`define PMS_CTRL_EN_BIT 0
`define PMS_CTRL_CLR_IRQ_BIT 1
`define PMS_CTRL_CLR_EXC_BIT 2
`define PMS_CTRL_EN_RST 1'b1

`endif

/* File: pkg/pms_pkg.sv */
package pms_pkg;

  typedef enum logic [3:0] {
    PMS_IDLE,
    PMS_PARSE,
    PMS_SKIP,
    PMS_CHECK,
    PMS_AUTH_WAIT,
    PMS_STANDBY,
    PMS_LOW_POWER_CARD_DETECT,
    PMS_LISTEN,
    PMS_LISTEN_SLEEP,
    PMS_LISTEN_HOLD
  } pms_state_t;

endpackage

/* File: hdl/pms_wake_timer.sv */
`timescale 1ns/1ns
module pms_wake_timer #(
  parameter int unsigned MS_CYCLES = 25000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic run,
  input wire logic [15:0] ms_count,
  output logic expired
);

  logic [31:0] pre_reg;
  logic [15:0] cnt_reg;
  logic ms_tick;

  // ****************************************
  // millisecond enable and down counter
  // ****************************************
  assign ms_tick = run && (pre_reg == 32'(MS_CYCLES - 1));
  // a zero load never expires
  assign expired = ms_tick && (cnt_reg == 16'h0001);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= 32'h0;
      cnt_reg <= 16'h0;
    end else if (start) begin
      pre_reg <= 32'h0;
      cnt_reg <= ms_count;
    end else if (run) begin
      pre_reg <= ms_tick ? 32'h0 : pre_reg + 32'h1;
      if (ms_tick && cnt_reg != 16'h0) begin
        cnt_reg <= cnt_reg - 16'h1;
      end
    end
  end

endmodule

/* File: hdl/pms_mode_cmd.sv */
`timescale 1ns/1ns
`include "pms_defs.svh"
// Function
// - mode-switch frame: code 0x0B, mode byte, then mode-dependent parameter bytes
// - mode switch only leaves normal operation, never returns to it
// - standby, card detection or listen end by themselves back to normal operation
// - mode byte 0 standby, 1 card detection, 2 listen; others rejected
// - standby takes wake mask then two-byte millisecond counter, 1 to 2690
// - wake mask: bit1 wakes on RF field, bit0 on counter, rest reserved zero
// - standby counter always sent, ignored when counter wake is off
// - end of standby, card detection or listen raises the interrupt
// - card detection counter sets period between attempts, 1 to 2690
// - listen mode takes technology mask and sub-mode 0 to 2
// - sub-mode 0 ends listening once the RF field is gone
// - sub-mode 1 sleeps without field, listens again when field returns
// - sub-mode 2 like sub-mode 1 but stays awake without field
// - technology mask: bit3 active F, bit2 active A, bit1 F, bit0 A
// - authentication frame: code 0x0C, six key bytes, key type 0x60 or 0x61
// - then block address, four id bytes; one status byte answered
// - violated parameter conditions raise an exception, nothing performed
// - status byte 0 success, 1 permission denied, 2 card timeout
module pms_mode_cmd #(
  parameter int unsigned MS_CYCLES = `PMS_MS_NS / `PMS_CLK_NS
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_LAST,
  output logic TX_VALID,
  output logic [7:0] TX_BYTE,
  output logic IRQ,
  output logic EXC,
  input wire logic RF_FIELD,
  input wire logic CARD_DETECTED,
  input wire logic LISTEN_DONE,
  input wire logic AUTH_DONE,
  input wire logic AUTH_DENIED,
  input wire logic AUTH_TIMEOUT,
  output logic AUTH_START,
  output logic [47:0] AUTH_KEY,
  output logic AUTH_KEY_B,
  output logic [7:0] AUTH_BLOCK,
  output logic [31:0] AUTH_UID,
  output logic SLEEP,
  output logic LOW_POWER_CARD_DETECT_PROBE,
  output logic LISTEN_ACTIVE,
  output logic [3:0] LISTEN_TECH,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);

  pms_pkg::pms_state_t state_reg;
  pms_pkg::pms_state_t state_next;
  logic auth_cmd_reg;
  logic [3:0] idx_reg;
  logic [7:0] mode_reg;
  logic [7:0] wctrl_reg;
  logic [15:0] wcnt_reg;
  logic [7:0] tech_reg;
  logic [7:0] sub_reg;
  logic [7:0] auth_buf [0:11];
  logic irq_reg;
  logic exc_flag_reg;
  logic exc_pulse_reg;
  logic tx_valid_reg;
  logic [7:0] tx_byte_reg;
  logic [7:0] auth_status_reg;
  logic auth_start_reg;
  logic en_reg;
  logic [31:0] rdata_reg;

  // ****************************************
  // frame decode
  // ****************************************
  wire take = RX_VALID && en_reg;
  wire op_switch = RX_BYTE == `PMS_OP_SWITCH;
  wire op_auth = RX_BYTE == `PMS_OP_AUTH;
  wire op_known = op_switch || op_auth;
  wire in_idle = state_reg == pms_pkg::PMS_IDLE;
  wire in_parse = state_reg == pms_pkg::PMS_PARSE;
  wire in_check = state_reg == pms_pkg::PMS_CHECK;
  wire in_standby = state_reg == pms_pkg::PMS_STANDBY;
  wire in_low_power_card_detect = state_reg == pms_pkg::PMS_LOW_POWER_CARD_DETECT;
  wire in_listen = state_reg == pms_pkg::PMS_LISTEN;
  wire in_lsleep = state_reg == pms_pkg::PMS_LISTEN_SLEEP;
  wire in_lhold = state_reg == pms_pkg::PMS_LISTEN_HOLD;
  wire in_mode = in_standby || in_low_power_card_detect || in_listen || in_lsleep || in_lhold;
  wire mode_sb = mode_reg == `PMS_MODE_STANDBY;
  wire mode_lp = mode_reg == `PMS_MODE_LOW_POWER_CARD_DETECT;
  wire mode_li = mode_reg == `PMS_MODE_LISTEN;
  wire param_wr = in_parse && RX_VALID;

  // ****************************************
  // parameter checks, evaluated on the full frame
  // ****************************************
  wire cnt_ok = (wcnt_reg >= `PMS_CNT_MIN) && (wcnt_reg <= `PMS_CNT_MAX);
  wire wake_cnt_en = wctrl_reg[`PMS_WAKE_CNT_BIT];
  wire wake_rf_en = wctrl_reg[`PMS_WAKE_RF_BIT];
  wire wctrl_ok = wctrl_reg[`PMS_WAKE_RSV_MSB:`PMS_WAKE_RSV_LSB] == '0;
  wire tech_ok = tech_reg[`PMS_TECH_RSV_MSB:`PMS_TECH_RSV_LSB] == '0;
  wire sub_ok = sub_reg <= `PMS_SUB_AWAKE;
  wire sb_ok = (idx_reg == `PMS_LEN_STANDBY) && wctrl_ok && (!wake_cnt_en || cnt_ok);
  wire lp_ok = (idx_reg == `PMS_LEN_LOW_POWER_CARD_DETECT) && cnt_ok;
  wire li_ok = (idx_reg == `PMS_LEN_LISTEN) && tech_ok && sub_ok;
  wire switch_ok = (mode_sb && sb_ok) || (mode_lp && lp_ok) || (mode_li && li_ok);
  wire [7:0] key_type_byte = auth_buf[`PMS_AUTH_TYPE_IDX];
  wire key_ok = (key_type_byte == `PMS_KEY_A) || (key_type_byte == `PMS_KEY_B);
  wire auth_ok = (idx_reg == `PMS_LEN_AUTH) && key_ok;
  wire frame_ok = auth_cmd_reg ? auth_ok : switch_ok;

  // ****************************************
  // mode timing and exits
  // ****************************************
  logic expired;
  wire timer_start = in_check || (in_low_power_card_detect && expired);
  wire timer_run = in_standby || in_low_power_card_detect;
  wire sb_wake = (wake_rf_en && RF_FIELD) || (wake_cnt_en && expired);
  wire lp_hit = in_low_power_card_detect && expired && CARD_DETECTED;
  wire mode_end = in_mode && (state_next == pms_pkg::PMS_IDLE);
  wire exc_event = (in_idle && take && op_known && RX_LAST) || (in_check && !frame_ok);
  wire [7:0] auth_code = AUTH_TIMEOUT ? `PMS_AUTH_TIMEOUT :
                         AUTH_DENIED ? `PMS_AUTH_DENIED : `PMS_AUTH_OK;

  pms_wake_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .clk(CLK),
    .resetn(RESETN),
    .start(timer_start),
    .run(timer_run),
    .ms_count(wcnt_reg),
    .expired(expired)
  );

  // ****************************************
  // control state machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pms_pkg::PMS_IDLE: begin
        if (take) begin
          if (op_known) begin
            state_next = RX_LAST ? pms_pkg::PMS_IDLE : pms_pkg::PMS_PARSE;
          end else if (!RX_LAST) begin
            state_next = pms_pkg::PMS_SKIP;
          end
        end
      end
      pms_pkg::PMS_PARSE: begin
        if (RX_VALID && RX_LAST) begin
          state_next = pms_pkg::PMS_CHECK;
        end
      end
      pms_pkg::PMS_SKIP: begin
        if (RX_VALID && RX_LAST) begin
          state_next = pms_pkg::PMS_IDLE;
        end
      end
      pms_pkg::PMS_CHECK: begin
        if (!frame_ok) begin
          state_next = pms_pkg::PMS_IDLE;
        end else if (auth_cmd_reg) begin
          state_next = pms_pkg::PMS_AUTH_WAIT;
        end else if (mode_sb) begin
          state_next = pms_pkg::PMS_STANDBY;
        end else if (mode_lp) begin
          state_next = pms_pkg::PMS_LOW_POWER_CARD_DETECT;
        end else begin
          state_next = pms_pkg::PMS_LISTEN;
        end
      end
      pms_pkg::PMS_AUTH_WAIT: begin
        if (AUTH_DONE) begin
          state_next = pms_pkg::PMS_IDLE;
        end
      end
      pms_pkg::PMS_STANDBY: begin
        if (sb_wake) begin
          state_next = pms_pkg::PMS_IDLE;
        end
      end
      pms_pkg::PMS_LOW_POWER_CARD_DETECT: begin
        if (lp_hit) begin
          state_next = pms_pkg::PMS_IDLE;
        end
      end
      pms_pkg::PMS_LISTEN: begin
        if (LISTEN_DONE) begin
          state_next = pms_pkg::PMS_IDLE;
        end else if (!RF_FIELD) begin
          if (sub_reg == `PMS_SUB_EXIT) begin
            state_next = pms_pkg::PMS_IDLE;
          end else if (sub_reg == `PMS_SUB_SLEEP) begin
            state_next = pms_pkg::PMS_LISTEN_SLEEP;
          end else begin
            state_next = pms_pkg::PMS_LISTEN_HOLD;
          end
        end
      end
      pms_pkg::PMS_LISTEN_SLEEP: begin
        if (RF_FIELD) begin
          state_next = pms_pkg::PMS_LISTEN;
        end
      end
      pms_pkg::PMS_LISTEN_HOLD: begin
        if (RF_FIELD) begin
          state_next = pms_pkg::PMS_LISTEN;
        end
      end
      default: begin
        state_next = pms_pkg::PMS_IDLE;
      end
    endcase
  end

  // frames during a mode are dropped until the mode ends
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= pms_pkg::PMS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // parameter capture
  // ****************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      auth_cmd_reg <= 1'b0;
      idx_reg <= 4'h0;
    end else if (in_idle && take) begin
      auth_cmd_reg <= op_auth;
      idx_reg <= 4'h0;
    end else if (param_wr && idx_reg != `PMS_IDX_MAX) begin
      idx_reg <= idx_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_reg <= 8'h0;
      wctrl_reg <= 8'h0;
      wcnt_reg <= 16'h0;
      tech_reg <= 8'h0;
      sub_reg <= 8'h0;
    end else if (param_wr && !auth_cmd_reg) begin
      if (idx_reg == `PMS_IDX_MODE) begin
        mode_reg <= RX_BYTE;
        wcnt_reg <= 16'h0;
      end else if (mode_sb) begin
        if (idx_reg == `PMS_IDX_P1) wctrl_reg <= RX_BYTE;
        if (idx_reg == `PMS_IDX_P2) wcnt_reg[7:0] <= RX_BYTE;
        if (idx_reg == `PMS_IDX_P3) wcnt_reg[15:8] <= RX_BYTE;
      end else if (mode_lp) begin
        if (idx_reg == `PMS_IDX_P1) wcnt_reg[7:0] <= RX_BYTE;
        if (idx_reg == `PMS_IDX_P2) wcnt_reg[15:8] <= RX_BYTE;
      end else begin
        if (idx_reg == `PMS_IDX_P1) tech_reg <= RX_BYTE;
        if (idx_reg == `PMS_IDX_P2) sub_reg <= RX_BYTE;
      end
    end
  end

  genvar k;
  generate
    for (k = 0; k < 12; k++) begin : g_auth
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          auth_buf[k] <= 8'h0;
        end else if (param_wr && auth_cmd_reg && idx_reg == 4'(k)) begin
          auth_buf[k] <= RX_BYTE;
        end
      end
      if (k < 6) begin : g_key
        assign AUTH_KEY[8*k +: 8] = auth_buf[k];
      end
      if (k >= `PMS_AUTH_UID_IDX) begin : g_uid
        assign AUTH_UID[8*(k-`PMS_AUTH_UID_IDX) +: 8] = auth_buf[k];
      end
    end
  endgenerate

  assign AUTH_KEY_B = key_type_byte == `PMS_KEY_B;
  assign AUTH_BLOCK = auth_buf[`PMS_AUTH_BLOCK_IDX];

  // ****************************************
  // events and answers
  // ****************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      exc_pulse_reg <= 1'b0;
      auth_start_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
    end else begin
      exc_pulse_reg <= exc_event;
      auth_start_reg <= in_check && frame_ok && auth_cmd_reg;
      tx_valid_reg <= (state_reg == pms_pkg::PMS_AUTH_WAIT) && AUTH_DONE;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_byte_reg <= 8'h0;
      auth_status_reg <= 8'h0;
    end else if ((state_reg == pms_pkg::PMS_AUTH_WAIT) && AUTH_DONE) begin
      tx_byte_reg <= auth_code;
      auth_status_reg <= auth_code;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  wire sel_ctrl = ADDR == `PMS_REG_CTRL;
  wire sel_status = ADDR == `PMS_REG_STATUS;
  wire sel_wake = ADDR == `PMS_REG_WAKE;
  wire sel_listen = ADDR == `PMS_REG_LISTEN;
  wire ctrl_wr = WR && sel_ctrl;
  wire clr_irq = ctrl_wr && WDATA[`PMS_CTRL_CLR_IRQ_BIT];
  wire clr_exc = ctrl_wr && WDATA[`PMS_CTRL_CLR_EXC_BIT];
  wire [31:0] status_word = {24'h0, 1'b0, !in_idle, mode_reg[1:0], LISTEN_ACTIVE, SLEEP, exc_flag_reg, irq_reg};
  wire [31:0] rd_mux = sel_ctrl ? {31'h0, en_reg} :
                       sel_status ? status_word :
                       sel_wake ? {8'h0, wcnt_reg, wctrl_reg} :
                       sel_listen ? {8'h0, auth_status_reg, sub_reg, tech_reg} : 32'h0;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      en_reg <= `PMS_CTRL_EN_RST;
      rdata_reg <= 32'h0;
    end else begin
      if (ctrl_wr) en_reg <= WDATA[`PMS_CTRL_EN_BIT];
      rdata_reg <= RD ? rd_mux : 32'h0;
    end
  end

  // sticky flags: a new event wins over a clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_reg <= 1'b0;
      exc_flag_reg <= 1'b0;
    end else begin
      irq_reg <= mode_end || (irq_reg && !clr_irq);
      exc_flag_reg <= exc_event || (exc_flag_reg && !clr_exc);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign TX_VALID = tx_valid_reg;
  assign TX_BYTE = tx_byte_reg;
  assign IRQ = irq_reg;
  assign EXC = exc_pulse_reg;
  assign AUTH_START = auth_start_reg;
  assign SLEEP = in_standby || in_low_power_card_detect || in_lsleep;
  assign LOW_POWER_CARD_DETECT_PROBE = in_low_power_card_detect && expired;
  assign LISTEN_ACTIVE = in_listen;
  assign LISTEN_TECH = tech_reg[3:0];
  assign RDATA = rdata_reg;

endmodule

/* File: test/pms_mode_cmd_sva.sv */
`timescale 1ns/1ns
`include "pms_defs.svh"
module pms_mode_cmd_sva #(
  parameter int unsigned MS_CYCLES = 25000
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic RD,
  input wire logic AUTH_DONE,
  input wire logic AUTH_DENIED,
  input wire logic AUTH_TIMEOUT,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_BYTE,
  input wire logic IRQ,
  input wire logic EXC,
  input wire logic AUTH_START,
  input wire logic SLEEP,
  input wire logic LOW_POWER_CARD_DETECT_PROBE,
  input wire logic LISTEN_ACTIVE,
  input wire logic [31:0] RDATA
);
  // ****
  // port checks
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  int gap;
  // cycles since the last probe
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN)
      gap <= 0;
    else
      gap <= LOW_POWER_CARD_DETECT_PROBE ? 1 : gap + 1;
  end
  exc_pulse_a: assert property (EXC |=> !EXC)
    else $error("exception longer than one cycle");
  exc_block_a: assert property (EXC |-> !AUTH_START && !SLEEP && !LISTEN_ACTIVE)
    else $error("operation performed beside exception");
  start_pulse_a: assert property (AUTH_START |=> !AUTH_START && !TX_VALID)
    else $error("auth start not a lone pulse");
  tx_cause_a: assert property (TX_VALID |-> $past(AUTH_DONE))
    else $error("status byte without auth done");
  status_code_a: assert property (TX_VALID |-> TX_BYTE == ($past(AUTH_TIMEOUT) ? `PMS_AUTH_TIMEOUT :
    $past(AUTH_DENIED) ? `PMS_AUTH_DENIED : `PMS_AUTH_OK)) else $error("wrong status byte");
  tx_hold_a: assert property ($changed(TX_BYTE) |-> TX_VALID)
    else $error("status byte changed without valid");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(SLEEP || LISTEN_ACTIVE) || $past(SLEEP || LISTEN_ACTIVE, 2))
    else $error("interrupt without mode end");
  probe_sleep_a: assert property (LOW_POWER_CARD_DETECT_PROBE |-> SLEEP)
    else $error("probe outside card detection");
  probe_gap_a: assert property (LOW_POWER_CARD_DETECT_PROBE |-> gap >= MS_CYCLES)
    else $error("probe period too short");
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data without read");
endmodule

/* File: test/pms_host_model.sv */
`timescale 1ns/1ns
module pms_host_model (
  input wire logic CLK,
  output logic RX_VALID,
  output logic [7:0] RX_BYTE,
  output logic RX_LAST
);
  // ****
  // host frame sender
  // ****
  initial begin
    RX_VALID = 1'b0;
    RX_BYTE = 8'h00;
    RX_LAST = 1'b0;
  end
  // code byte first, then parameters, last flagged
  task automatic send(input logic [7:0] frm [16], input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge CLK);
      RX_VALID <= 1'b1;
      RX_BYTE <= frm[i];
      RX_LAST <= (i == len - 1);
    end
    @(posedge CLK);
    RX_VALID <= 1'b0;
    RX_LAST <= 1'b0;
    RX_BYTE <= ~RX_BYTE;
  endtask
endmodule

/* File: test/pms_mode_cmd_bench.sv */
`timescale 1ns/1ns
`include "pms_defs.svh"
module pms_mode_cmd_bench;
  // ****
  // stimulus and checks
  // ****
  localparam int MSC = 10;
  localparam logic [67:0] BAD [10] = '{68'h5_0000_0000_0000_030b, 68'h5_0000_0000_0104_000b,
    68'h5_0000_0000_0001_000b, 68'h5_0000_000a_8301_000b, 68'h4_0000_0000_0000_010b,
    68'h4_0000_0000_0301_020b, 68'h4_0000_0000_0010_020b, 68'h1_0000_0000_0000_000b,
    68'hd_6200_0000_0000_000c, 68'h4_0000_0000_0101_000b};
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic RF_FIELD = 1'b0, CARD_DETECTED = 1'b0, LISTEN_DONE = 1'b0, WR = 1'b0, RD = 1'b0;
  logic AUTH_DONE = 1'b0, AUTH_DENIED = 1'b0, AUTH_TIMEOUT = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic RX_VALID, RX_LAST, TX_VALID, IRQ, EXC, AUTH_START, AUTH_KEY_B, SLEEP, LOW_POWER_CARD_DETECT_PROBE, LISTEN_ACTIVE;
  logic [7:0] RX_BYTE, TX_BYTE, AUTH_BLOCK;
  logic [47:0] AUTH_KEY;
  logic [31:0] AUTH_UID, RDATA;
  logic [3:0] LISTEN_TECH;
  logic [7:0] f [16];
  int error_cnt = 0;
  int num_checks = 0;
  always #20 CLK = ~CLK;
  pms_host_model u_host (.CLK(CLK), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE), .RX_LAST(RX_LAST));
  pms_mode_cmd #(.MS_CYCLES(MSC)) u_dut (.CLK(CLK), .RESETN(RESETN), .RX_VALID(RX_VALID),
    .RX_BYTE(RX_BYTE), .RX_LAST(RX_LAST), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .IRQ(IRQ), .EXC(EXC),
    .RF_FIELD(RF_FIELD), .CARD_DETECTED(CARD_DETECTED), .LISTEN_DONE(LISTEN_DONE), .AUTH_DONE(AUTH_DONE),
    .AUTH_DENIED(AUTH_DENIED), .AUTH_TIMEOUT(AUTH_TIMEOUT), .AUTH_START(AUTH_START), .AUTH_KEY(AUTH_KEY),
    .AUTH_KEY_B(AUTH_KEY_B), .AUTH_BLOCK(AUTH_BLOCK), .AUTH_UID(AUTH_UID), .SLEEP(SLEEP),
    .LOW_POWER_CARD_DETECT_PROBE(LOW_POWER_CARD_DETECT_PROBE), .LISTEN_ACTIVE(LISTEN_ACTIVE), .LISTEN_TECH(LISTEN_TECH), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // bounded wait for one event, current cycle included
  task automatic wt(input int s, input int n);
    logic [8:0] v;
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      #1;
      v = {LOW_POWER_CARD_DETECT_PROBE, !LISTEN_ACTIVE, LISTEN_ACTIVE, !SLEEP, SLEEP, IRQ, TX_VALID, AUTH_START, EXC};
      hit = v[s];
      if (hit === 1'b1)
        break;
      @(posedge CLK);
    end
    chk(hit, 1'b1);
    if (hit !== 1'b1)
      test_done();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic clr;
    wr(`PMS_REG_CTRL, 32'h3);
    #1;
    chk(IRQ, 1'b0);
  endtask
  task automatic sw(input logic [7:0] m, a, b, c, input int n);
    f = '{default: 8'h00};
    f[0] = `PMS_OP_SWITCH;
    f[1] = m;
    f[2] = a;
    f[3] = b;
    f[4] = c;
    u_host.send(f, n);
  endtask
  task automatic t_bus;
    logic [31:0] d;
    rd(`PMS_REG_CTRL, d);
    chk(d[0], `PMS_CTRL_EN_RST);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, d);
    chk(d, 32'h0);
    wr(`PMS_REG_CTRL, 32'h0);
    sw(`PMS_MODE_STANDBY, 8'h01, 8'h01, 8'h00, 5);
    repeat (6) @(posedge CLK);
    #1;
    chk(SLEEP, 1'b0);
    wr(`PMS_REG_CTRL, 32'h1);
  endtask
  task automatic t_standby;
    logic [31:0] d;
    int n;
    sw(`PMS_MODE_STANDBY, 8'h01, 8'h02, 8'h00, 5);
    wt(4, 8);
    for (n = 0; n < 40; n++) begin
      @(posedge CLK);
      #1;
      if (SLEEP !== 1'b1)
        break;
    end
    chk(n >= 2 * MSC - 3 && n <= 2 * MSC + 2, 1'b1);
    wt(3, 4);
    rd(`PMS_REG_WAKE, d);
    chk(d[23:0], 24'h000201);
    clr();
    sw(`PMS_MODE_STANDBY, 8'h02, 8'h00, 8'h00, 5);
    wt(4, 8);
    @(posedge CLK);
    RF_FIELD <= 1'b1;
    wt(5, 4);
    wt(3, 4);
    @(posedge CLK);
    RF_FIELD <= 1'b0;
    clr();
  endtask
  task automatic t_low_power_card_detect;
    int n;
    sw(`PMS_MODE_LOW_POWER_CARD_DETECT, 8'h01, 8'h00, 8'h00, 4);
    wt(8, 30);
    for (n = 1; n < 40; n++) begin
      @(posedge CLK);
      #1;
      if (LOW_POWER_CARD_DETECT_PROBE === 1'b1)
        break;
    end
    chk(n >= MSC && n <= MSC + 1, 1'b1);
    @(posedge CLK);
    CARD_DETECTED <= 1'b1;
    wt(5, 30);
    wt(3, 4);
    @(posedge CLK);
    CARD_DETECTED <= 1'b0;
    clr();
  endtask
  task automatic t_listen(input logic [7:0] sub, input logic [7:0] tech);
    @(posedge CLK);
    RF_FIELD <= (sub == `PMS_SUB_EXIT);
    sw(`PMS_MODE_LISTEN, tech, sub, 8'h00, 4);
    if (sub == `PMS_SUB_EXIT) begin
      wt(6, 8);
      chk(LISTEN_TECH, tech[3:0]);
      @(posedge CLK);
      RF_FIELD <= 1'b0;
      wt(7, 4);
    end else begin
      repeat (6) @(posedge CLK);
      #1;
      chk(SLEEP, sub == `PMS_SUB_SLEEP);
      @(posedge CLK);
      RF_FIELD <= 1'b1;
      wt(6, 6);
      chk(SLEEP, 1'b0);
      @(posedge CLK);
      LISTEN_DONE <= 1'b1;
      @(posedge CLK);
      LISTEN_DONE <= 1'b0;
    end
    wt(3, 4);
    @(posedge CLK);
    RF_FIELD <= 1'b0;
    clr();
  endtask
  task automatic t_exc;
    logic [31:0] d;
    for (int i = 0; i < 10; i++) begin
      f = '{default: 8'h00};
      for (int j = 0; j < 8; j++)
        f[j] = BAD[i][8*j +: 8];
      u_host.send(f, int'(BAD[i][67:64]));
      wt(0, 6);
      chk(SLEEP, 1'b0);
    end
    rd(`PMS_REG_STATUS, d);
    chk(d[1], 1'b1);
    wr(`PMS_REG_CTRL, 32'h5);
    rd(`PMS_REG_STATUS, d);
    chk(d[1], 1'b0);
  endtask
  task automatic t_auth(input int c);
    f[0] = `PMS_OP_AUTH;
    for (int j = 1; j < 13; j++)
      f[j] = 8'(j * 17 + c);
    f[7] = (c == 1) ? `PMS_KEY_B : `PMS_KEY_A;
    u_host.send(f, 13);
    wt(1, 6);
    chk(AUTH_KEY, {f[6], f[5], f[4], f[3], f[2], f[1]});
    chk(AUTH_KEY_B, c == 1);
    chk(AUTH_BLOCK, f[8]);
    chk(AUTH_UID, {f[12], f[11], f[10], f[9]});
    @(posedge CLK);
    AUTH_DONE <= 1'b1;
    AUTH_DENIED <= (c == 1);
    AUTH_TIMEOUT <= (c == 2);
    @(posedge CLK);
    AUTH_DONE <= 1'b0;
    wt(2, 3);
    chk(TX_BYTE, (c == 2) ? `PMS_AUTH_TIMEOUT : (c == 1) ? `PMS_AUTH_DENIED : `PMS_AUTH_OK);
  endtask
  task automatic t_reset;
    sw(`PMS_MODE_STANDBY, 8'h00, 8'h01, 8'h00, 5);
    repeat (40) @(posedge CLK);
    #1;
    chk(SLEEP, 1'b1);
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    #1;
    chk(SLEEP, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    t_bus();
    t_standby();
    t_low_power_card_detect();
    t_listen(`PMS_SUB_EXIT, 8'h0f);
    t_listen(`PMS_SUB_SLEEP, 8'h05);
    t_listen(`PMS_SUB_AWAKE, 8'h0a);
    t_exc();
    for (int c = 0; c < 3; c++)
      t_auth(c);
    t_reset();
    test_done();
  end
endmodule
bind pms_mode_cmd pms_mode_cmd_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.CLK(CLK), .RESETN(RESETN), .RD(RD),
  .AUTH_DONE(AUTH_DONE), .AUTH_DENIED(AUTH_DENIED), .AUTH_TIMEOUT(AUTH_TIMEOUT), .TX_VALID(TX_VALID),
  .TX_BYTE(TX_BYTE), .IRQ(IRQ), .EXC(EXC), .AUTH_START(AUTH_START), .SLEEP(SLEEP),
  .LOW_POWER_CARD_DETECT_PROBE(LOW_POWER_CARD_DETECT_PROBE), .LISTEN_ACTIVE(LISTEN_ACTIVE), .RDATA(RDATA));
